// File: verilog/tmc_map.svh
/*
  Register offsets, field positions, reset values and fixed priorities of the
  traffic manager control register set. Assumes APB byte addressing, 12-bit.
*/
// How it works
// - suspend select bit 2 picks realtime debug suspend, 0 picks ordinary one
// - free-run bit set makes the block ignore emulation suspend requests
// - read-only 12-bit idle vector; bit 11 is AND of bits 10-0
// - software 32-bit timestamp is distributed to every submodule data logger
// - 24-bit read-only hardware timestamp counter sits in status bits 23-0
// - run bit low holds counter at zero; high increments it every clock
// - bits 26-16 force logger hold, bits 10-0 force logger idle, overriding
// - control bits 15-8 give the descriptor info-word source identifier
// - control bit 2 masks the incoming packet DMA TX request and active signals for loopback; RX DMA write requests are not masked
// - bit 1 forces payload endian conversion even when device is not big-endian
// - control bit 0 raises read priority of TX DMA paths with active packets
// - TX DMA read arbitration uses 2-bit priority per queue, 0 at 1-0
// - 2-bit destination port select per TX queue, queue 0 at 17-16
// - TX queue read arbitration uses 2-bit priorities in bits 15-0
// - RX queue writes arbitrate four ports by 2-bit priority, two registers
// - RX writes toward packet DMA use 2-bit priority per queue
// - per-processor 11-bit interrupt status, set and cleared by separate registers
// - processor halt mask over status bits; bit 11 forces halt
// - 64-entry flow table supplies flags, output queue, format, endian, type
// - per-flow 4-bit processor select picks who gets error interrupts
// - input format code decodes into unit, reverse or swap; input endian code passes through unchanged
// - no further interrupt to a processor until acknowledge is written
// - error halt ends once the interrupt source has been cleared
`ifndef TMC_MAP_SVH
`define TMC_MAP_SVH
`define TMC_A_SUSP 12'h010
`define TMC_A_IDLE 12'h014
`define TMC_A_SWTS 12'h018
`define TMC_A_HWTS 12'h01c
`define TMC_A_TSRUN 12'h020
`define TMC_A_LOG 12'h024
`define TMC_A_CTRL 12'h028
`define TMC_A_TXDRP 12'h02c
`define TMC_A_TXQSEL 12'h030
`define TMC_A_RXQLO 12'h034
`define TMC_A_RXQHI 12'h038
`define TMC_A_RXDWP 12'h03c
`define TMC_A_ISTAT 12'h040
`define TMC_A_HMASK 12'h044
`define TMC_CPU_STRIDE 12'h008
`define TMC_A_EOI 12'h060
`define TMC_A_ISET 12'h080
`define TMC_A_ICLR 12'h090
`define TMC_A_TABLE 4'h1
`define TMC_SUSP_SEL 2
`define TMC_SUSP_FREE 0
`define TMC_CTRL_DMA_OFF 2
`define TMC_CTRL_FRC_END 1
`define TMC_CTRL_BOOST 0
`define TMC_FORCE_STOP 11
`define TMC_RST_WORD 32'h0000_0000
`define TMC_BOOST_PRIO 2'h3
`define TMC_EOI_VALUE 8'h00
`endif

// File: verilog/tmc_pkg.sv
/*
  Types of the traffic manager control register set.
  Assumes nothing beyond the register map header.
*/
package tmc_pkg;
  typedef struct packed {
    logic [3:0] rsvd_hi;
    logic [3:0] protocol_flags;
    logic [2:0] output_queue_select;
    logic [2:0] format_out;
    logic [1:0] endian_out;
    logic [3:0] cpu_select;
    logic [4:0] pkt_type;
    logic [1:0] rsvd_lo;
    logic [2:0] format_in;
    logic [1:0] endian_in;
  } tmc_flow_t;
  typedef enum logic [1:0] {TMC_U32, TMC_U16, TMC_U8, TMC_UNONE} tmc_unit_t;
endpackage : tmc_pkg

// File: verilog/tmc_mem_if.sv
/*
  Port bundle between the register set and its flow table memory.
  Assumes one write port and two registered read ports.
*/
interface tmc_mem_if #(parameter int AW = 6, parameter int DW = 32);
  logic we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] a_addr;
  logic [DW-1:0] a_data;
  logic [AW-1:0] b_addr;
  logic [DW-1:0] b_data;
  modport ctl (output we, waddr, wdata, a_addr, b_addr, input a_data, b_data);
  modport mem (input we, waddr, wdata, a_addr, b_addr, output a_data, b_data);
endinterface : tmc_mem_if

// File: verilog/tmc_flow_mem.sv
/*
  Flow table storage: one write port, two read ports with registered data.
  Assumes one clock; contents are undefined until written.
*/
module tmc_flow_mem #(
  parameter int AW = 6,
  parameter int DW = 32
) (
  input wire logic pclk,
  tmc_mem_if.mem m
);
  logic [DW-1:0] arr [2**AW];

  always_ff @(posedge pclk)
  begin
    if (m.we)
    begin
      arr[m.waddr] <= m.wdata;
    end
    m.a_data <= arr[m.a_addr];
    m.b_data <= arr[m.b_addr];
  end
endmodule : tmc_flow_mem

// File: verilog/tmc_regs.sv
/*
  Traffic manager control and status registers with their arbiters,
  interrupt status, halt logic and flow table lookup.
  Assumes an APB master on pclk; suspend requests arrive asynchronously,
  all other inputs come from logic on pclk.
*/
`include "tmc_map.svh"
module tmc_regs #(
  parameter int FLOW_AW = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic debug_suspend_req,
  input wire logic realtime_debug_suspend,
  output logic suspend_out,
  input wire logic [10:0] submodule_idle,
  output logic [31:0] sw_timestamp,
  output logic [23:0] log_time_counter,
  output logic [10:0] logger_hold_state,
  output logic [10:0] logger_idle_state,
  output logic [7:0] descriptor_source_id,
  input wire logic device_big_endian,
  output logic payload_convert_en,
  input wire logic [7:0] dma_tx_req,
  input wire logic [7:0] dma_tx_active,
  output logic [7:0] tx_dma_rd_grant,
  input wire logic [7:0] tx_queue_rd_req,
  output logic [7:0] tx_queue_rd_grant,
  output logic [15:0] tx_queue_port_select,
  input wire logic [31:0] rx_queue_wr_req,
  output logic [31:0] rx_queue_wr_grant,
  input wire logic [7:0] rx_dma_wr_req,
  output logic [7:0] rx_dma_wr_grant,
  input wire logic err_valid,
  input wire logic [10:0] err_submodule,
  input wire logic [FLOW_AW-1:0] err_flow_id,
  output logic [3:0] cpu_irq,
  output logic cpu_halt,
  input wire logic [FLOW_AW-1:0] lookup_flow_id,
  output logic [3:0] protocol_flags,
  output logic [2:0] output_queue_select,
  output logic [2:0] format_out,
  output logic [1:0] endian_out,
  output logic [4:0] pkt_type,
  output logic in_reverse,
  output logic in_swap,
  output logic [1:0] in_unit,
  output logic [1:0] in_endian_word
);
  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  logic pready_r, pslverr_r;
  logic [31:0] prdata_r, rd_val;
  logic [2:0] susp_r;
  logic [31:0] swts_r, log_r, ctrl_r, txdrp_r, txqsel_r, rxqlo_r, rxqhi_r, rxdwp_r;
  logic run_r;
  logic [23:0] ts_r;
  logic [10:0] stat_r [4];
  logic [11:0] hmask_r [4];
  logic [3:0] blk_r, irq_r;
  logic halt_r;

  wire access = psel & penable;
  wire done = access & pready_r;
  wire wr = done & pwrite;
  wire hit_susp = paddr == `TMC_A_SUSP;
  wire hit_idle = paddr == `TMC_A_IDLE;
  wire hit_swts = paddr == `TMC_A_SWTS;
  wire hit_hwts = paddr == `TMC_A_HWTS;
  wire hit_run = paddr == `TMC_A_TSRUN;
  wire hit_log = paddr == `TMC_A_LOG;
  wire hit_ctrl = paddr == `TMC_A_CTRL;
  wire hit_txdrp = paddr == `TMC_A_TXDRP;
  wire hit_txqsel = paddr == `TMC_A_TXQSEL;
  wire hit_rxqlo = paddr == `TMC_A_RXQLO;
  wire hit_rxqhi = paddr == `TMC_A_RXQHI;
  wire hit_rxdwp = paddr == `TMC_A_RXDWP;
  wire hit_eoi = paddr == `TMC_A_EOI;
  wire hit_tab = (paddr[11:8] == `TMC_A_TABLE) && (paddr[1:0] == 2'h0);
  wire eoi_w = wr & hit_eoi & (pwdata[7:0] == `TMC_EOI_VALUE);
  wire [3:0] hit_cpu;
  wire [31:0] rd_cpu [4];
  wire [10:0] set_w [4];
  wire [10:0] clr_w [4];
  wire [3:0] stop_c;

  wire [11:0] idle_vec = {&submodule_idle, submodule_idle};
  wire [31:0] rd_reg =
      ({32{hit_susp}} & {29'h0, susp_r[2], 1'b0, susp_r[0]})
    | ({32{hit_idle}} & {20'h0, idle_vec})
    | ({32{hit_swts}} & swts_r)
    | ({32{hit_hwts}} & {8'h0, ts_r})
    | ({32{hit_run}} & {31'h0, run_r})
    | ({32{hit_log}} & log_r)
    | ({32{hit_ctrl}} & ctrl_r)
    | ({32{hit_txdrp}} & txdrp_r)
    | ({32{hit_txqsel}} & txqsel_r)
    | ({32{hit_rxqlo}} & rxqlo_r)
    | ({32{hit_rxqhi}} & rxqhi_r)
    | ({32{hit_rxdwp}} & rxdwp_r)
    | rd_cpu[0] | rd_cpu[1] | rd_cpu[2] | rd_cpu[3];
  wire mapped = hit_susp | hit_idle | hit_swts | hit_hwts | hit_run | hit_log
    | hit_ctrl | hit_txdrp | hit_txqsel | hit_rxqlo | hit_rxqhi | hit_rxdwp
    | hit_eoi | hit_tab | (|hit_cpu);

  tmc_mem_if #(.AW(FLOW_AW), .DW(32)) mif ();
  tmc_flow_mem #(.AW(FLOW_AW), .DW(32)) u_mem (.pclk(pclk), .m(mif));

  // table reads borrow the lookup port while the bus selects the block
  assign mif.we = wr & hit_tab;
  assign mif.waddr = paddr[FLOW_AW+1:2];
  assign mif.wdata = pwdata;
  assign mif.a_addr = psel ? paddr[FLOW_AW+1:2] : lookup_flow_id;
  assign mif.b_addr = err_flow_id;
  assign rd_val = hit_tab ? mif.a_data : rd_reg;

  // one wait state on every access so the table word is ready
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= `TMC_RST_WORD;
    end
    else
    begin
      pready_r <= access & ~pready_r;
      pslverr_r <= access & ~pready_r & ~mapped;
      if (access && !pready_r && !pwrite)
      begin
        prdata_r <= rd_val;
      end
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      susp_r <= 3'h0;
      swts_r <= `TMC_RST_WORD;
      run_r <= 1'b0;
      log_r <= `TMC_RST_WORD;
      ctrl_r <= `TMC_RST_WORD;
      txdrp_r <= `TMC_RST_WORD;
      txqsel_r <= `TMC_RST_WORD;
      rxqlo_r <= `TMC_RST_WORD;
      rxqhi_r <= `TMC_RST_WORD;
      rxdwp_r <= `TMC_RST_WORD;
    end
    else if (wr)
    begin
      if (hit_susp) susp_r <= {pwdata[`TMC_SUSP_SEL], 1'b0, pwdata[`TMC_SUSP_FREE]};
      if (hit_swts) swts_r <= pwdata;
      if (hit_run) run_r <= pwdata[0];
      if (hit_log) log_r <= {5'h0, pwdata[26:16], 5'h0, pwdata[10:0]};
      if (hit_ctrl) ctrl_r <= {16'h0, pwdata[15:8], 5'h0, pwdata[2:0]};
      if (hit_txdrp) txdrp_r <= {16'h0, pwdata[15:0]};
      if (hit_txqsel) txqsel_r <= pwdata;
      if (hit_rxqlo) rxqlo_r <= pwdata;
      if (hit_rxqhi) rxqhi_r <= pwdata;
      if (hit_rxdwp) rxdwp_r <= {16'h0, pwdata[15:0]};
    end
  end

  // ----------------------------------------
  // suspend and timestamp
  // ----------------------------------------
  logic [1:0] susp_s1_r, susp_s2_r;
  logic suspend_r, conv_r;
  wire susp_pick = susp_r[`TMC_SUSP_SEL] ? susp_s2_r[1] : susp_s2_r[0];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      susp_s1_r <= 2'h0;
      susp_s2_r <= 2'h0;
      suspend_r <= 1'b0;
      ts_r <= 24'h0;
      conv_r <= 1'b0;
    end
    else
    begin
      susp_s1_r <= {realtime_debug_suspend, debug_suspend_req};
      susp_s2_r <= susp_s1_r;
      suspend_r <= susp_pick & ~susp_r[`TMC_SUSP_FREE];
      ts_r <= run_r ? ts_r + 24'h1 : 24'h0;
      conv_r <= device_big_endian | ctrl_r[`TMC_CTRL_FRC_END];
    end
  end

  // ----------------------------------------
  // arbiters
  // ----------------------------------------
  // highest priority wins; equal ones go to the first after the last grant
  function automatic logic [3:0] arb_pick(input logic [7:0] req,
                                          input logic [15:0] pri,
                                          input logic [2:0] ptr);
    logic [1:0] best;
    logic [3:0] res;
    logic [2:0] k;
    best = 2'h0;
    res = 4'h0;
    for (int i = 0; i < 8; i++)
    begin
      if (req[i] && pri[2*i +: 2] > best) best = pri[2*i +: 2];
    end
    for (int i = 8; i >= 1; i--)
    begin
      k = ptr + 3'(i);
      if (req[k] && pri[2*k +: 2] == best) res = {1'b1, k};
    end
    return res;
  endfunction : arb_pick

  wire [7:0] dma_req_m = ctrl_r[`TMC_CTRL_DMA_OFF] ? 8'h0 : dma_tx_req;
  wire [7:0] dma_act_m = ctrl_r[`TMC_CTRL_DMA_OFF] ? 8'h0 : dma_tx_active;
  wire [63:0] rxq_pri = {rxqhi_r, rxqlo_r};
  wire [7:0] arb_req [11];
  wire [15:0] arb_pri [11];
  logic [7:0] gnt_r [11];
  logic [2:0] ptr_r [11];
  wire [15:0] boost_pri;

  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_boost
      assign boost_pri[2*g +: 2] = (ctrl_r[`TMC_CTRL_BOOST] && dma_act_m[g]) ?
        `TMC_BOOST_PRIO : txdrp_r[2*g +: 2];
      assign arb_req[3+g] = {4'h0, rx_queue_wr_req[4*g +: 4]};
      assign arb_pri[3+g] = {8'h0, rxq_pri[8*g +: 8]};
      assign rx_queue_wr_grant[4*g +: 4] = gnt_r[3+g][3:0];
    end
  endgenerate
  assign arb_req[0] = dma_req_m;
  assign arb_pri[0] = boost_pri;
  assign arb_req[1] = tx_queue_rd_req;
  assign arb_pri[1] = txqsel_r[15:0];
  assign arb_req[2] = rx_dma_wr_req;
  assign arb_pri[2] = rxdwp_r[15:0];

  generate
    for (g = 0; g < 11; g++)
    begin : g_arb
      wire [3:0] pick = arb_pick(arb_req[g], arb_pri[g], ptr_r[g]);
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          gnt_r[g] <= 8'h0;
          ptr_r[g] <= 3'h7;
        end
        else
        begin
          gnt_r[g] <= pick[3] ? (8'h1 << pick[2:0]) : 8'h0;
          if (pick[3]) ptr_r[g] <= pick[2:0];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // interrupt status and halt
  // ----------------------------------------
  logic err_v_r;
  logic [10:0] err_src_r;
  wire [3:0] err_cpu = mif.b_data[15:12];

  generate
    for (g = 0; g < 4; g++)
    begin : g_cpu
      wire hit_st = paddr == 12'(`TMC_A_ISTAT + `TMC_CPU_STRIDE * g);
      wire hit_hm = paddr == 12'(`TMC_A_HMASK + `TMC_CPU_STRIDE * g);
      wire hit_set = paddr == 12'(`TMC_A_ISET + 12'h4 * g);
      wire hit_clr = paddr == 12'(`TMC_A_ICLR + 12'h4 * g);
      wire [10:0] ev = (err_v_r && err_cpu[g]) ? err_src_r : 11'h0;
      assign hit_cpu[g] = hit_st | hit_hm | hit_set | hit_clr;
      assign rd_cpu[g] = ({32{hit_st}} & {21'h0, stat_r[g]})
        | ({32{hit_hm}} & {20'h0, hmask_r[g]});
      assign set_w[g] = (wr && hit_set) ? pwdata[10:0] : 11'h0;
      assign clr_w[g] = (wr && hit_clr) ? pwdata[10:0] : 11'h0;
      assign stop_c[g] = (|(stat_r[g] & hmask_r[g][10:0]))
        | hmask_r[g][`TMC_FORCE_STOP];
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          stat_r[g] <= 11'h0;
          hmask_r[g] <= 12'h0;
          blk_r[g] <= 1'b0;
          irq_r[g] <= 1'b0;
        end
        else
        begin
          stat_r[g] <= (stat_r[g] & ~clr_w[g]) | set_w[g] | ev;
          if (wr && hit_hm) hmask_r[g] <= pwdata[11:0];
          // one pulse only: the block flag lands a cycle after the pulse
          irq_r[g] <= (|stat_r[g]) & ~blk_r[g] & ~irq_r[g];
          blk_r[g] <= irq_r[g] | (blk_r[g] & ~eoi_w);
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      err_v_r <= 1'b0;
      err_src_r <= 11'h0;
      halt_r <= 1'b0;
    end
    else
    begin
      err_v_r <= err_valid;
      err_src_r <= err_submodule;
      halt_r <= |stop_c;
    end
  end

  // ----------------------------------------
  // flow lookup
  // ----------------------------------------
  tmc_pkg::tmc_flow_t flow_r;
  logic [1:0] unit_r;
  logic rev_r, swp_r;
  tmc_pkg::tmc_flow_t flow_w;
  assign flow_w = mif.a_data;
  wire [2:0] fin = flow_w.format_in;
  wire [1:0] unit_w = (fin[1:0] == 2'h1) ? tmc_pkg::TMC_U32 :
                      (fin[1:0] == 2'h2) ? tmc_pkg::TMC_U16 :
                      (fin[1:0] == 2'h3) ? tmc_pkg::TMC_U8 : tmc_pkg::TMC_UNONE;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flow_r <= '0;
      unit_r <= 2'h0;
      rev_r <= 1'b0;
      swp_r <= 1'b0;
    end
    else
    begin
      flow_r <= flow_w;
      unit_r <= unit_w;
      rev_r <= ~fin[2] & (fin[1:0] != 2'h0);
      swp_r <= fin[2] & (fin[1:0] != 2'h0);
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign suspend_out = suspend_r;
  assign sw_timestamp = swts_r;
  assign log_time_counter = ts_r;
  assign logger_hold_state = log_r[26:16];
  assign logger_idle_state = log_r[10:0];
  assign descriptor_source_id = ctrl_r[15:8];
  assign payload_convert_en = conv_r;
  assign tx_dma_rd_grant = gnt_r[0];
  assign tx_queue_rd_grant = gnt_r[1];
  assign rx_dma_wr_grant = gnt_r[2];
  assign tx_queue_port_select = txqsel_r[31:16];
  assign cpu_irq = irq_r;
  assign cpu_halt = halt_r;
  assign protocol_flags = flow_r.protocol_flags;
  assign output_queue_select = flow_r.output_queue_select;
  assign format_out = flow_r.format_out;
  assign endian_out = flow_r.endian_out;
  assign pkt_type = flow_r.pkt_type;
  assign in_reverse = rev_r;
  assign in_swap = swp_r;
  assign in_unit = unit_r;
  assign in_endian_word = flow_r.endian_in;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_free; susp_r[0] |=> !suspend_out; endproperty
  a_free: assert property (p_free) else $error("suspend seen in free-run");
  property p_rtsel; !susp_r[0] && susp_r[2] && susp_s2_r[1] |=> suspend_out; endproperty
  a_rtsel: assert property (p_rtsel) else $error("realtime suspend lost");
  property p_idle; hit_idle |-> rd_val[11] == &submodule_idle; endproperty
  a_idle: assert property (p_idle) else $error("idle summary wrong");
  property p_tsinc; run_r |=> log_time_counter == 24'($past(log_time_counter) + 24'h1);
  endproperty
  a_tsinc: assert property (p_tsinc) else $error("timestamp not counting");
  property p_tszero; !run_r ##1 !run_r |=> log_time_counter == 24'h0; endproperty
  a_tszero: assert property (p_tszero) else $error("timestamp not held");
  property p_dmaoff; ctrl_r[2] |=> tx_dma_rd_grant == 8'h0; endproperty
  a_dmaoff: assert property (p_dmaoff) else $error("grant while dma masked");
  property p_arb; |tx_queue_rd_req |=> $onehot(tx_queue_rd_grant); endproperty
  a_arb: assert property (p_arb) else $error("read arbiter idle");
  property p_halt; (|(stat_r[0] & hmask_r[0][10:0])) |=> cpu_halt; endproperty
  a_halt: assert property (p_halt) else $error("halt missed");
  property p_irq; cpu_irq[0] ##1 !eoi_w |=> !cpu_irq[0]; endproperty
  a_irq: assert property (p_irq) else $error("irq before acknowledge");
  property p_pulse; cpu_irq[0] |=> !cpu_irq[0]; endproperty
  a_pulse: assert property (p_pulse) else $error("irq longer than one cycle");
endmodule : tmc_regs

// File: verif/tmc_far_model.sv
/*
  Far-side model: packet DMA engine and submodule ports raising arbitration
  requests. Assumes the bench loads a request pattern and grants are one-hot.
*/
module tmc_far_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [7:0] want,
  input wire logic [7:0] act,
  input wire logic [7:0] tx_dma_rd_grant,
  input wire logic [7:0] tx_queue_rd_grant,
  input wire logic [7:0] rx_dma_wr_grant,
  input wire logic [31:0] rx_queue_wr_grant,
  output logic [7:0] dma_tx_req,
  output logic [7:0] dma_tx_active,
  output logic [7:0] tx_queue_rd_req,
  output logic [7:0] rx_dma_wr_req,
  output logic [31:0] rx_queue_wr_req
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [55:0] req_r;
  logic [55:0] gnt;
  assign gnt = {tx_dma_rd_grant, tx_queue_rd_grant, rx_dma_wr_grant, rx_queue_wr_grant};
  // a requester holds its request until it has seen its grant
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      req_r <= '0;
    else if (load)
      req_r <= {want, want, want, {4{want}}};
    else
      req_r <= req_r & ~gnt;
  end
  assign {dma_tx_req, tx_queue_rd_req, rx_dma_wr_req, rx_queue_wr_req} = req_r;
  assign dma_tx_active = act & dma_tx_req;
endmodule : tmc_far_model

// File: verif/traffic_manager_control_regs_tb.sv
/*
  Self-checking bench for the control register set, APB master tasks.
  Assumes one pclk domain and the far-side request model.
*/
`include "tmc_map.svh"
module traffic_manager_control_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, sw_timestamp, rx_queue_wr_req, rx_queue_wr_grant;
  logic debug_suspend_req = 0, realtime_debug_suspend = 0, suspend_out;
  logic [10:0] submodule_idle = '0, logger_hold_state, logger_idle_state;
  logic [10:0] err_submodule = '0;
  logic [23:0] log_time_counter, t0;
  logic [7:0] descriptor_source_id, dma_tx_req, dma_tx_active, tx_dma_rd_grant;
  logic [7:0] tx_queue_rd_req, tx_queue_rd_grant, rx_dma_wr_req, rx_dma_wr_grant;
  logic [15:0] tx_queue_port_select;
  logic device_big_endian = 0, payload_convert_en, err_valid = 0, cpu_halt;
  logic in_reverse, in_swap, load = 0;
  logic [5:0] err_flow_id = '0, lookup_flow_id = '0;
  logic [3:0] cpu_irq, protocol_flags, irq_or = '0;
  logic [2:0] output_queue_select, format_out;
  logic [1:0] endian_out, in_unit, in_endian_word;
  logic [4:0] pkt_type;
  logic [7:0] want = '0, act = '0;
  logic [31:0] rd_v;
  logic rd_e;
  logic [55:0] first, acc;
  int bad_count = 0, checks_done = 0, cyc = 0, irq_cnt = 0;
  tmc_regs u_tmc_regs (.*);
  tmc_far_model u_tmc_far_model (.*);
  always #20 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc++;
    irq_or <= irq_or | cpu_irq;
    if (cpu_irq[0] === 1'b1)
      irq_cnt++;
    if (cyc == 6000)
    begin
      bad_count++;
      summarize();
    end
  end
  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_v = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic cmp(input logic [55:0] got, input logic [55:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic collect();
    want <= 8'hff;
    load <= 1'b1;
    @(posedge pclk);
    load <= 1'b0;
    first = '0;
    acc = '0;
    repeat (30)
    begin
      @(posedge pclk);
      if (first == '0)
        first = {tx_dma_rd_grant, tx_queue_rd_grant, rx_dma_wr_grant, rx_queue_wr_grant};
      acc |= {tx_dma_rd_grant, tx_queue_rd_grant, rx_dma_wr_grant, rx_queue_wr_grant};
    end
  endtask : collect
  task automatic error_event(input logic [10:0] sub);
    err_valid <= 1'b1;
    err_submodule <= sub;
    err_flow_id <= 6'h03;
    @(posedge pclk);
    err_valid <= 1'b0;
    repeat (10) @(posedge pclk);
  endtask : error_event
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize
  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 'h10; a <= 'h60; a += 4)
    begin
      apb(1'b0, 12'(a), '0);
      cmp(rd_v, 56'h0);
    end
    apb(1'b0, 12'h0f0, '0);
    cmp({rd_e, rd_v}, 56'h1_0000_0000);
    apb(1'b1, `TMC_A_SWTS, 32'hdead_beef);
    cmp(sw_timestamp, 56'hdead_beef);
    apb(1'b1, `TMC_A_LOG, 32'h0555_02aa);
    cmp({logger_hold_state, logger_idle_state}, {11'h555, 11'h2aa});
    apb(1'b1, `TMC_A_CTRL, 32'h0000_5a00);
    cmp(descriptor_source_id, 56'h5a);
    submodule_idle <= 11'h7ff;
    apb(1'b0, `TMC_A_IDLE, '0);
    cmp(rd_v, 56'hfff);
    submodule_idle <= 11'h7fe;
    apb(1'b0, `TMC_A_IDLE, '0);
    cmp(rd_v, 56'h7fe);
    $display("test registers done");
    apb(1'b1, `TMC_A_TSRUN, 32'h1);
    @(posedge pclk);
    t0 = log_time_counter;
    repeat (7) @(posedge pclk);
    cmp(log_time_counter - t0, 56'h7);
    apb(1'b0, `TMC_A_HWTS, '0);
    cmp(rd_v[31:24], 56'h0);
    apb(1'b1, `TMC_A_TSRUN, 32'h0);
    repeat (2) @(posedge pclk);
    cmp(log_time_counter, 56'h0);
    $display("test timestamp done");
    apb(1'b1, `TMC_A_SUSP, 32'h4);
    realtime_debug_suspend <= 1'b1;
    repeat (5) @(posedge pclk);
    cmp(suspend_out, 56'h1);
    realtime_debug_suspend <= 1'b0;
    debug_suspend_req <= 1'b1;
    repeat (5) @(posedge pclk);
    cmp(suspend_out, 56'h0);
    apb(1'b1, `TMC_A_SUSP, 32'h0);
    repeat (5) @(posedge pclk);
    cmp(suspend_out, 56'h1);
    apb(1'b1, `TMC_A_SUSP, 32'h1);
    repeat (5) @(posedge pclk);
    cmp(suspend_out, 56'h0);
    debug_suspend_req <= 1'b0;
    $display("test suspend done");
    apb(1'b1, `TMC_A_CTRL, 32'h2);
    @(posedge pclk);
    cmp(payload_convert_en, 56'h1);
    apb(1'b1, `TMC_A_TXDRP, 32'h0000_0030);
    apb(1'b1, `TMC_A_TXQSEL, 32'hc3a5_c000);
    cmp(tx_queue_port_select, 56'hc3a5);
    apb(1'b1, `TMC_A_RXDWP, 32'h0000_0c00);
    apb(1'b1, `TMC_A_RXQLO, 32'h0000_00c0);
    apb(1'b1, `TMC_A_RXQHI, 32'h0c00_0000);
    collect();
    cmp(first & 56'hffffff_f000000f, 56'h048020_20000008);
    cmp(acc, {56{1'b1}});
    apb(1'b1, `TMC_A_TXDRP, 32'h0);
    apb(1'b1, `TMC_A_CTRL, 32'h1);
    act <= 8'h40;
    collect();
    cmp(first[55:48], 56'h40);
    act <= 8'h00;
    apb(1'b1, `TMC_A_CTRL, 32'h4);
    collect();
    cmp(acc[55:48], 56'h0);
    apb(1'b1, `TMC_A_CTRL, 32'h0);
    repeat (30) @(posedge pclk);
    $display("test arbitration done");
    for (int f = 0; f < 8; f++)
    begin
      apb(1'b1, 12'h100 + 12'(4 * f), {8'h0a, 3'(f), 5'h05, 4'h1, 5'h13, 2'h0, 3'(f), 2'(f)});
      lookup_flow_id <= 6'(f);
      repeat (3) @(posedge pclk);
      cmp({protocol_flags, output_queue_select, pkt_type, in_endian_word},
          {4'ha, 3'(f), 5'h13, 2'(f)});
      cmp({in_reverse, in_swap}, {f >= 1 && f <= 3, f >= 5});
      cmp({format_out, endian_out}, 56'h05);
      cmp(in_unit, (f % 4 == 0) ? 56'h3 : 56'((f % 4) - 1));
    end
    $display("test flow table done");
    apb(1'b1, `TMC_A_HMASK, 32'h8);
    error_event(11'h008);
    cmp(irq_cnt, 56'h1);
    cmp(irq_or, 56'h1);
    cmp(cpu_halt, 56'h1);
    apb(1'b0, `TMC_A_ISTAT, '0);
    cmp(rd_v, 56'h008);
    error_event(11'h010);
    cmp(irq_cnt, 56'h1);
    apb(1'b1, `TMC_A_EOI, 32'h0);
    repeat (10) @(posedge pclk);
    cmp(irq_cnt, 56'h2);
    apb(1'b1, `TMC_A_ICLR, 32'h018);
    repeat (2) @(posedge pclk);
    cmp(cpu_halt, 56'h0);
    apb(1'b0, `TMC_A_ISTAT, '0);
    cmp(rd_v, 56'h0);
    apb(1'b1, `TMC_A_HMASK, 32'h800);
    @(posedge pclk);
    cmp(cpu_halt, 56'h1);
    $display("test interrupts done");
    summarize();
  end
endmodule : traffic_manager_control_regs_tb
